// ### hsp_pkg.sv
// Purpose: Shared constants, types and decoders for the serial register port and its host end.
// Assumes: Link clock idles high between bytes; the host end makes it by dividing MCLK.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// RULE1 - Straps sampled only during hardware reset
// RULE2 - Board holds dynamic straps during reset only
// RULE3 - Strobe and latch straps pick bus type
// RULE4 - All straps low means management channel only
// RULE5 - Board ties unused selection pins to levels
// RULE6 - Interrupt active low after reset, reprogrammable
// RULE7 - Select falls to start, rises to end
// RULE8 - Sample on rising, drive on falling clock
// RULE9 - Eight-bit bytes, most significant bit first
// RULE10 - First byte is header choosing sequence
// RULE11 - Header bit two selects upper register half
// RULE12 - Header 40: alternating, read slot non-interleaved
// RULE13 - Header 48: read data during next address
// RULE14 - Header 43: one address, then data bytes
// RULE15 - Burst FIFO addresses use advancing pointer
// RULE16 - Header 41: non-interleaved reads, then write burst
// RULE17 - Header 49: interleaved reads, then write burst
// RULE18 - Write address ends read phase, starts burst
// RULE19 - Address byte top bit marks a read
// RULE20 - Idle transmit outside read slots; select clears
package hsp_pkg;

  localparam logic [2:0] BIT_FIRST    = 3'h0;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] BIT_STEP     = 3'h1;
  localparam int         HDR_HALF_BIT = 2;
  localparam logic [7:0] HDR_HALF_MSK = 8'h04;
  localparam logic [7:0] HDR_ALT_NI   = 8'h40;
  localparam logic [7:0] HDR_ALT_IL   = 8'h48;
  localparam logic [7:0] HDR_CONST    = 8'h43;
  localparam logic [7:0] HDR_RDWR_NI  = 8'h41;
  localparam logic [7:0] HDR_RDWR_IL  = 8'h49;
  localparam int         ADR_RD_BIT   = 7;
  localparam logic [6:0] FIFO_LO_LAST = 7'h1F;
  localparam logic [6:0] FIFO_ALT_A   = 7'h6A;
  localparam logic [6:0] FIFO_ALT_B   = 7'h7A;
  localparam int         PTR_W        = 7;
  localparam logic [6:0] PTR_RESET    = 7'h00;
  localparam logic [6:0] PTR_STEP     = 7'h01;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;
  localparam logic [3:0] HALF_DIV     = 4'h4;
  localparam logic [3:0] GAP_DIV      = 4'h8;
  localparam logic [3:0] HALF_LOAD    = HALF_DIV - CNT_ONE;
  localparam logic [3:0] GAP_LOAD     = GAP_DIV - CNT_ONE;

  typedef enum logic [2:0] {HOST_NONE, HOST_SERIAL, HOST_PAR_STROBE_DIR, HOST_PAR_SEPARATE,
                            HOST_PAR_MUX, HOST_UNDEF} host_if_t;
  typedef enum logic [2:0] {SEQ_ALT_NI, SEQ_ALT_IL, SEQ_CONST, SEQ_RDWR_NI, SEQ_RDWR_IL, SEQ_BAD} seq_t;

  // Both register halves share one code set once bit two is masked off.
  function automatic seq_t decode_header(input logic [7:0] h);
    logic [7:0] base;
    base = h & ~HDR_HALF_MSK;
    case (base)
      HDR_ALT_NI:  decode_header = SEQ_ALT_NI;
      HDR_ALT_IL:  decode_header = SEQ_ALT_IL;
      HDR_CONST:   decode_header = SEQ_CONST;
      HDR_RDWR_NI: decode_header = SEQ_RDWR_NI;
      HDR_RDWR_IL: decode_header = SEQ_RDWR_IL;
      default:     decode_header = SEQ_BAD;
    endcase
  endfunction : decode_header

  function automatic logic is_fifo_addr(input logic [6:0] a);
    is_fifo_addr = (a <= FIFO_LO_LAST) || (a == FIFO_ALT_A) || (a == FIFO_ALT_B);
  endfunction : is_fifo_addr

  // Strap levels as caught during reset; edge marks any latch-strobe transition.
  function automatic host_if_t decode_straps(input logic wr, input logic rd, input logic cs,
                                             input logic lat, input logic edge_seen);
    if (wr && rd && cs) begin
      decode_straps = edge_seen ? HOST_PAR_MUX : (lat ? HOST_PAR_STROBE_DIR : HOST_PAR_SEPARATE);
    end else if (!wr && !rd && !lat && !edge_seen) begin
      decode_straps = cs ? HOST_SERIAL : HOST_NONE;
    end else begin
      decode_straps = HOST_UNDEF;
    end
  endfunction : decode_straps

endpackage : hsp_pkg

// ### serial_port_if.sv
// Purpose: Four-wire serial link between host end and device end.
// Assumes: Transmit line is pulled high when the device does not drive it.
// Notes: tx_level is the resolved wire the host listens to.
interface serial_port_if;
  logic sclk;
  logic cs_n;
  logic rx;
  logic tx_o;
  logic tx_oe;
  logic tx_level;

  // Pull-up on the shared transmit wire.
  assign tx_level = tx_oe ? tx_o : 1'b1;

  modport device (input sclk, input cs_n, input rx, output tx_o, output tx_oe);
  modport host (output sclk, output cs_n, output rx, input tx_level);
endinterface : serial_port_if

// ### sync2.sv
// Purpose: Two-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is a level or a toggle; bits are not related words.
// Notes: The first stage feeds only the second stage.
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Plain two-stage capture.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sync2

// ### serial_port_device.sv
// Purpose: Device end of the serial register port with host interface strap decode.
// Assumes: Host leaves at least a few MCLK cycles between bytes with the link clock high.
// Notes: Link logic runs on the link clock; sequence and transmit state clear while select is high, the request word does not.
module serial_port_device (
  input  wire logic            MCLK,
  input  wire logic            NRST,
  serial_port_if.device        LNK,
  input  wire logic            HARDWARE_RESET_IN,
  input  wire logic            STRAP_WR,
  input  wire logic            STRAP_RD,
  input  wire logic            STRAP_LATCH,
  input  wire logic            IRQ_REQ,
  input  wire logic            IRQ_ACTIVE_HIGH,
  input  wire logic [7:0]      REG_RDATA,
  output logic                 REG_WR,
  output logic                 REG_RD,
  output logic [7:0]           REG_ADDR,
  output logic [7:0]           REG_WDATA,
  output logic                 REG_FIFO,
  output logic [6:0]           REG_FIFO_PTR,
  output hsp_pkg::host_if_t    HOST_IF,
  output logic                 MGMT_ONLY,
  output logic                 INT_LINE
);
  import hsp_pkg::*;

  typedef enum {LS_HDR, LS_ADR, LS_WDATA, LS_RDSLOT, LS_BURST, LS_DROP} lstate_t;

  // Link-domain sequence state, cleared by select high.
  lstate_t          state_reg, state_next;
  logic [2:0]       bit_cnt_reg, bit_cnt_next;
  logic [6:0]       rx_sh_reg, rx_sh_next;
  seq_t             seq_reg, seq_next;
  logic             half_reg, half_next;
  logic [6:0]       addr_reg, addr_next;
  logic             fifo_reg, fifo_next;
  logic             rd_mode_reg, rd_mode_next;
  logic             send_reg, send_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  // Link-domain request word, held across frames so its toggle never glitches.
  logic             req_tgl_reg, req_tgl_next;
  logic             req_wr_reg, req_wr_next;
  logic [7:0]       req_addr_reg, req_addr_next;
  logic [7:0]       req_data_reg, req_data_next;
  logic             req_fifo_reg, req_fifo_next;
  logic [PTR_W-1:0] req_ptr_reg, req_ptr_next;
  // Link-domain transmit side on the falling edge.
  logic [7:0]       tx_sh_reg, tx_sh_next;
  logic             tx_oe_reg, tx_oe_next;
  // MCLK-domain state.
  logic [5:0]       sync_q;
  logic             hwr_s, wr_s, rd_s, lat_s, cs_s, req_s;
  logic             hwr_prev_reg, lat_prev_reg, req_seen_reg;
  logic             wr_cap_reg, rd_cap_reg, cs_cap_reg, lat_cap_reg, edge_reg;
  host_if_t         mode_reg;
  logic [7:0]       rdata_reg;
  logic             frame_rst_n;
  logic             serial_en;
  // Byte assembly helpers.
  logic [7:0]       byte_in;
  logic             issue_rd, issue_wr;
  logic [6:0]       req_a;
  logic             req_f;
  logic [PTR_W-1:0] req_p;

  assign serial_en   = (mode_reg == HOST_SERIAL);
  // Select high ends the frame and clears all sequence state.
  assign frame_rst_n = NRST & ~LNK.cs_n & serial_en; // RULE7 RULE20

  // Sequence decoder: acts once per completed byte.
  always_comb begin
    byte_in       = {rx_sh_reg, LNK.rx}; // RULE9
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg + BIT_STEP;
    rx_sh_next    = byte_in[6:0];
    seq_next      = seq_reg;
    half_next     = half_reg;
    addr_next     = addr_reg;
    fifo_next     = fifo_reg;
    rd_mode_next  = rd_mode_reg;
    send_next     = send_reg;
    ptr_next      = ptr_reg;
    issue_rd      = 1'b0;
    issue_wr      = 1'b0;
    req_a         = addr_reg;
    req_f         = fifo_reg;
    req_p         = ptr_reg;
    if (bit_cnt_reg == BIT_LAST) begin
      case (state_reg)
        LS_HDR: begin
          seq_next   = decode_header(byte_in); // RULE10
          half_next  = byte_in[HDR_HALF_BIT]; // RULE11
          state_next = (decode_header(byte_in) == SEQ_BAD) ? LS_DROP : LS_ADR;
        end
        LS_ADR: begin
          addr_next    = byte_in[6:0];
          fifo_next    = is_fifo_addr(byte_in[6:0]) && (seq_reg == SEQ_CONST); // RULE15
          rd_mode_next = byte_in[ADR_RD_BIT]; // RULE19
          req_a        = byte_in[6:0];
          req_f        = is_fifo_addr(byte_in[6:0]) && (seq_reg == SEQ_CONST);
          if (byte_in[ADR_RD_BIT]) begin
            issue_rd = 1'b1;
            case (seq_reg)
              SEQ_ALT_NI, SEQ_RDWR_NI: state_next = LS_RDSLOT; // RULE12 RULE16
              SEQ_CONST:               state_next = LS_BURST; // RULE14
              default:                 state_next = LS_ADR; // RULE13 RULE17
            endcase
          end else begin
            case (seq_reg)
              SEQ_ALT_NI, SEQ_ALT_IL: state_next = LS_WDATA;
              default:                state_next = LS_BURST; // RULE18
            endcase
          end
        end
        LS_WDATA: begin
          issue_wr   = 1'b1;
          state_next = LS_ADR;
        end
        LS_RDSLOT: begin
          state_next = LS_ADR; // RULE12
        end
        LS_BURST: begin
          ptr_next = ptr_reg + PTR_STEP; // RULE15
          if (rd_mode_reg) begin
            issue_rd = 1'b1;
            req_p    = ptr_reg + PTR_STEP;
          end else begin
            issue_wr = 1'b1; // RULE14 RULE18
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
      send_next = issue_rd;
    end
  end

  // Request word for the MCLK side; it stays put until the next completed byte.
  always_comb begin
    req_tgl_next  = req_tgl_reg;
    req_wr_next   = req_wr_reg;
    req_addr_next = req_addr_reg;
    req_data_next = req_data_reg;
    req_fifo_next = req_fifo_reg;
    req_ptr_next  = req_ptr_reg;
    if (issue_rd || issue_wr) begin
      req_tgl_next  = ~req_tgl_reg;
      req_wr_next   = issue_wr;
      req_addr_next = {half_reg, req_a}; // RULE11
      req_data_next = byte_in;
      req_fifo_next = req_f;
      req_ptr_next  = req_p;
    end
  end

  // Receive side samples on the rising link clock.
  always_ff @(posedge LNK.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_reg   <= LS_HDR;
      bit_cnt_reg <= BIT_FIRST;
      rx_sh_reg   <= '0;
      seq_reg     <= SEQ_BAD;
      half_reg    <= 1'b0;
      addr_reg    <= '0;
      fifo_reg    <= 1'b0;
      rd_mode_reg <= 1'b0;
      send_reg    <= 1'b0;
      ptr_reg     <= PTR_RESET;
    end else begin
      state_reg   <= state_next; // RULE8
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg   <= rx_sh_next;
      seq_reg     <= seq_next;
      half_reg    <= half_next;
      addr_reg    <= addr_next;
      fifo_reg    <= fifo_next;
      rd_mode_reg <= rd_mode_next;
      send_reg    <= send_next;
      ptr_reg     <= ptr_next;
    end
  end

  // Request word registers; reset only by the system reset.
  always_ff @(posedge LNK.sclk or negedge NRST) begin
    if (!NRST) begin
      req_tgl_reg  <= 1'b0;
      req_wr_reg   <= 1'b0;
      req_addr_reg <= '0;
      req_data_reg <= '0;
      req_fifo_reg <= 1'b0;
      req_ptr_reg  <= PTR_RESET;
    end else begin
      req_tgl_reg  <= req_tgl_next;
      req_wr_reg   <= req_wr_next;
      req_addr_reg <= req_addr_next;
      req_data_reg <= req_data_next;
      req_fifo_reg <= req_fifo_next;
      req_ptr_reg  <= req_ptr_next;
    end
  end

  // Transmit loads read data at the first falling edge of a read slot.
  // The read word is taken straight from MCLK flops; the inter-byte gap keeps it settled.
  always_comb begin
    tx_sh_next = {tx_sh_reg[6:0], IDLE_BYTE[0]};
    tx_oe_next = tx_oe_reg;
    if (bit_cnt_reg == BIT_FIRST) begin
      tx_oe_next = send_reg; // RULE20
      tx_sh_next = send_reg ? rdata_reg : IDLE_BYTE; // RULE12 RULE13
    end
  end

  always_ff @(negedge LNK.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_sh_reg <= IDLE_BYTE;
      tx_oe_reg <= 1'b0;
    end else begin
      tx_sh_reg <= tx_sh_next; // RULE8
      tx_oe_reg <= tx_oe_next;
    end
  end

  assign LNK.tx_o  = tx_sh_reg[7]; // RULE9
  assign LNK.tx_oe = tx_oe_reg;

  // Pins and the request toggle enter MCLK through one synchroniser bank.
  sync2 #(.W(6)) u_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .d     ({HARDWARE_RESET_IN, STRAP_WR, STRAP_RD, STRAP_LATCH, LNK.cs_n, req_tgl_reg}),
    .q     (sync_q)
  );
  assign {hwr_s, wr_s, rd_s, lat_s, cs_s, req_s} = sync_q;

  // Straps are caught while reset is held and decoded when it releases.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      hwr_prev_reg <= 1'b0;
      lat_prev_reg <= 1'b0;
      wr_cap_reg   <= 1'b0;
      rd_cap_reg   <= 1'b0;
      cs_cap_reg   <= 1'b0;
      lat_cap_reg  <= 1'b0;
      edge_reg     <= 1'b0;
      mode_reg     <= HOST_NONE;
    end else begin
      hwr_prev_reg <= hwr_s;
      lat_prev_reg <= lat_s;
      if (hwr_s) begin
        wr_cap_reg  <= wr_s; // RULE1
        rd_cap_reg  <= rd_s;
        cs_cap_reg  <= cs_s;
        lat_cap_reg <= lat_s;
        edge_reg    <= (hwr_prev_reg && (lat_s != lat_prev_reg)) || (edge_reg && hwr_prev_reg);
      end
      if (hwr_prev_reg && !hwr_s) begin
        mode_reg <= decode_straps(wr_cap_reg, rd_cap_reg, cs_cap_reg, lat_cap_reg, edge_reg); // RULE3 RULE4
      end
    end
  end

  // Register access pulses; read data is captured the cycle after the read pulse.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      req_seen_reg <= 1'b0;
      rdata_reg    <= IDLE_BYTE;
      REG_WR       <= 1'b0;
      REG_RD       <= 1'b0;
      REG_ADDR     <= '0;
      REG_WDATA    <= '0;
      REG_FIFO     <= 1'b0;
      REG_FIFO_PTR <= PTR_RESET;
    end else begin
      req_seen_reg <= req_s;
      REG_WR       <= (req_s != req_seen_reg) && req_wr_reg;
      REG_RD       <= (req_s != req_seen_reg) && !req_wr_reg;
      if (req_s != req_seen_reg) begin
        REG_ADDR     <= req_addr_reg;
        REG_WDATA    <= req_data_reg;
        REG_FIFO     <= req_fifo_reg;
        REG_FIFO_PTR <= req_ptr_reg;
      end
      if (REG_RD) begin
        rdata_reg <= REG_RDATA;
      end
    end
  end

  // Interrupt line idles high because the default polarity is active low.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      INT_LINE  <= 1'b1;
      HOST_IF   <= HOST_NONE;
      MGMT_ONLY <= 1'b0;
    end else begin
      INT_LINE  <= IRQ_ACTIVE_HIGH ? IRQ_REQ : ~IRQ_REQ; // RULE6
      HOST_IF   <= mode_reg;
      MGMT_ONLY <= (mode_reg == HOST_NONE); // RULE4
    end
  end

endmodule : serial_port_device

// ### serial_port_host.sv
// Purpose: Host end that drives select and a divided serial clock, one byte per command.
// Assumes: The user sends the header as the first byte of every frame.
// Notes: Clock idles high; each byte is eight falling/rising pairs, then a gap.
module serial_port_host (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  serial_port_if.host      LNK,
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_BYTE,
  input  wire logic        CMD_LAST,
  output logic             CMD_READY,
  output logic             RSP_VALID,
  output logic [7:0]       RSP_BYTE
);
  import hsp_pkg::*;

  typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_END} hstate_t;

  hstate_t    state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic       last_reg, last_next;
  logic       sclk_reg, sclk_next;
  logic       cs_n_reg, cs_n_next;
  logic       mosi_reg, mosi_next;
  logic       ready_next, rsp_valid_next;
  logic [7:0] rsp_byte_next;
  logic       miso_s;

  // The returned line is another domain's output, so it is synchronised first.
  sync2 #(.W(1)) u_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .d     (LNK.tx_level),
    .q     (miso_s)
  );

  // Byte sequencer: counts half periods and gaps down to zero.
  always_comb begin
    state_next     = state_reg;
    cnt_next       = (cnt_reg != CNT_ZERO) ? cnt_reg - CNT_ONE : CNT_ZERO;
    bit_next       = bit_reg;
    tx_sh_next     = tx_sh_reg;
    rx_sh_next     = rx_sh_reg;
    last_next      = last_reg;
    sclk_next      = sclk_reg;
    cs_n_next      = cs_n_reg;
    mosi_next      = mosi_reg;
    rsp_valid_next = 1'b0;
    rsp_byte_next  = RSP_BYTE;
    case (state_reg)
      H_IDLE, H_GAP: begin
        if (CMD_READY && CMD_VALID) begin
          tx_sh_next = CMD_BYTE;
          last_next  = CMD_LAST;
          cs_n_next  = 1'b0; // RULE7
          cnt_next   = HALF_LOAD;
          state_next = H_SETUP;
        end
      end
      H_SETUP: begin
        if (cnt_reg == CNT_ZERO) begin
          sclk_next  = 1'b0;
          mosi_next  = tx_sh_reg[7]; // RULE9
          bit_next   = BIT_FIRST;
          cnt_next   = HALF_LOAD;
          state_next = H_LOW;
        end
      end
      H_LOW: begin
        if (cnt_reg == CNT_ZERO) begin
          sclk_next  = 1'b1;
          rx_sh_next = {rx_sh_reg[6:0], miso_s};
          cnt_next   = HALF_LOAD;
          state_next = H_HIGH;
        end
      end
      H_HIGH: begin
        if (cnt_reg == CNT_ZERO) begin
          if (bit_reg == BIT_LAST) begin
            rsp_valid_next = 1'b1;
            rsp_byte_next  = rx_sh_reg;
            cnt_next       = last_reg ? HALF_LOAD : GAP_LOAD;
            state_next     = last_reg ? H_END : H_GAP;
          end else begin
            bit_next   = bit_reg + BIT_STEP;
            tx_sh_next = {tx_sh_reg[6:0], IDLE_BYTE[0]};
            mosi_next  = tx_sh_reg[6];
            sclk_next  = 1'b0;
            cnt_next   = HALF_LOAD;
            state_next = H_LOW;
          end
        end
      end
      H_END: begin
        if (cnt_reg == CNT_ZERO) begin
          cs_n_next  = 1'b1; // RULE7
          mosi_next  = 1'b1;
          cnt_next   = HALF_LOAD;
          state_next = H_IDLE;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
    ready_next = ((state_next == H_IDLE) || (state_next == H_GAP)) && (cnt_next == CNT_ZERO);
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= H_IDLE;
      cnt_reg   <= CNT_ZERO;
      bit_reg   <= BIT_FIRST;
      tx_sh_reg <= IDLE_BYTE;
      rx_sh_reg <= '0;
      last_reg  <= 1'b0;
      sclk_reg  <= 1'b1;
      cs_n_reg  <= 1'b1;
      mosi_reg  <= 1'b1;
      CMD_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_BYTE  <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      last_reg  <= last_next;
      sclk_reg  <= sclk_next;
      cs_n_reg  <= cs_n_next;
      mosi_reg  <= mosi_next;
      CMD_READY <= ready_next;
      RSP_VALID <= rsp_valid_next;
      RSP_BYTE  <= rsp_byte_next;
    end
  end

  assign LNK.sclk = sclk_reg;
  assign LNK.cs_n = cs_n_reg;
  assign LNK.rx   = mosi_reg;

endmodule : serial_port_host

// ### link_asserts.sv
// Purpose: Wire-level checks on the link between the host end and the device end.
// Assumes: Link signals are sampled on MCLK; the link clock is many MCLK cycles long.
// Notes: Bit counters restart while select is high, so a torn frame never leaks into the next.
module link_asserts (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rx,
  input wire logic tx_o,
  input wire logic tx_oe,
  input wire logic tx_level
);
  logic       sclk_reg, sclk_next, hdr_reg, hdr_next, rise;
  logic [2:0] bit_reg, bit_next, oe_reg, oe_next;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  // Count link clock rises per frame and per driven slot; the header flag marks the first whole byte.
  always_comb begin
    rise      = sclk && !sclk_reg;
    sclk_next = sclk;
    bit_next  = cs_n ? 3'h0 : bit_reg + {2'h0, rise};
    oe_next   = cs_n ? 3'h0 : oe_reg + {2'h0, rise && tx_oe};
    hdr_next  = !cs_n && (hdr_reg || (rise && bit_reg == 3'h7));
  end

  // Registers only; the clock idles high, so that is its reset level.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sclk_reg <= 1'b1;
      bit_reg  <= 3'h0;
      oe_reg   <= 3'h0;
      hdr_reg  <= 1'b0;
    end else begin
      sclk_reg <= sclk_next;
      bit_reg  <= bit_next;
      oe_reg   <= oe_next;
      hdr_reg  <= hdr_next;
    end
  end

  chk_tx_quiet_idle: assert property (cs_n && $past(cs_n) |-> !tx_oe) else $error("Transmit driven while idle.");
  chk_sclk_idle_high: assert property (cs_n && $past(cs_n) |-> sclk) else $error("Link clock low while idle.");
  chk_frame_setup: assert property ($fell(cs_n) |-> sclk [*3]) else $error("Link clock fell at select.");
  chk_whole_bytes: assert property ($rose(cs_n) |-> bit_reg == 3'h0) else $error("Frame ended mid byte.");
  chk_rx_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(rx) |-> $fell(sclk)) else $error("Rx moved late.");
  chk_tx_on_fall: assert property (!cs_n && $past(!cs_n) && ($changed(tx_o) || $changed(tx_oe)) |-> $fell(sclk))
    else $error("Tx moved off falling edge.");
  chk_slot_whole: assert property ($fell(tx_oe) && !cs_n |-> oe_reg == 3'h0) else $error("Read slot not 8 bits.");
  chk_header_quiet: assert property (tx_oe |-> hdr_reg) else $error("Transmit driven in header.");
endmodule : link_asserts

// ### host_serial_register_port_tb_top.sv
// Purpose: Joins both ends over the link and runs strap, interrupt and sequence tests.
// Assumes: Bench drives inputs 1 ns after the rising MCLK edge.
// Notes: Rows hold {last, check, byte, expected reply}; the register stand-in returns the inverted address, except for FIFO reads.
module host_serial_register_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hsp_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst, hw_reset, strap_wr, strap_rd, strap_latch, irq_req, irq_high, cmd_valid, cmd_last;
  logic        cmd_ready, rsp_valid, reg_wr, reg_rd, reg_fifo, mgmt_only, int_line;
  logic [7:0]  cmd_byte, rsp_byte, reg_rdata, reg_addr, reg_wdata;
  logic [6:0]  reg_fifo_ptr;
  host_if_t    host_if;
  int          failures, cmp_count, rd_count;
  logic [23:0] wlog[$];
  logic [19:0] frames[37] = '{20'h04000, 20'h00500, 20'h0A500, 20'h08500, 20'h3FFFA,
    20'h04C00, 20'h08300, 20'h1907C, 20'h1116F, 20'h23C00, 20'h04300, 20'h01F00, 20'h0D000, 20'h0D100, 20'h2D200,
    20'h04300, 20'h0EA00, 20'h1FF6A, 20'h1FF68, 20'h3FF6E, 20'h04300, 20'h02000, 20'h21100,
    20'h04100, 20'h08200, 20'h1FFFD, 20'h00700, 20'h00100, 20'h20200, 20'h04900, 20'h08100, 20'h108FE,
    20'h03300, 20'h24400, 20'h04200, 20'h00500, 20'h27700};
  logic [23:0] writes[10] = '{24'h05A500, 24'h913C00, 24'h1FD080, 24'h1FD181, 24'h1FD282,
    24'h201100, 24'h070100, 24'h070200, 24'h083300, 24'h084400};

  serial_port_if u_serial_port_if ();
  serial_port_device u_serial_port_device (.MCLK(mclk), .NRST(nrst), .LNK(u_serial_port_if),
    .HARDWARE_RESET_IN(hw_reset), .STRAP_WR(strap_wr), .STRAP_RD(strap_rd), .STRAP_LATCH(strap_latch),
    .IRQ_REQ(irq_req), .IRQ_ACTIVE_HIGH(irq_high), .REG_RDATA(reg_rdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_FIFO(reg_fifo), .REG_FIFO_PTR(reg_fifo_ptr),
    .HOST_IF(host_if), .MGMT_ONLY(mgmt_only), .INT_LINE(int_line));
  serial_port_host u_serial_port_host (.MCLK(mclk), .NRST(nrst), .LNK(u_serial_port_if), .CMD_VALID(cmd_valid),
    .CMD_BYTE(cmd_byte), .CMD_LAST(cmd_last), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte));
  link_asserts u_link_asserts (.MCLK(mclk), .NRST(nrst), .sclk(u_serial_port_if.sclk), .cs_n(u_serial_port_if.cs_n),
    .rx(u_serial_port_if.rx), .tx_o(u_serial_port_if.tx_o), .tx_oe(u_serial_port_if.tx_oe),
    .tx_level(u_serial_port_if.tx_level));

  always #10 mclk = ~mclk;

  // Register stand-in: FIFO reads fold in the pointer so slot order shows in the replies.
  assign reg_rdata = reg_fifo ? (reg_addr ^ {reg_fifo_ptr, 1'b0}) : ~reg_addr;
  always @(posedge mclk) if (reg_wr === 1'b1) wlog.push_back({reg_addr, reg_wdata, reg_fifo, reg_fifo_ptr});
  always @(posedge mclk) if (reg_rd === 1'b1) rd_count++;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Straps are set before the reset pulse and kept after it, then the write strap is flipped to show the mode stays put.
  task automatic strap(input logic [3:0] s, input host_if_t exp);
    {strap_wr, strap_rd, strap_latch} = s[3:1];
    repeat (2) @(posedge mclk);
    #1 hw_reset = 1'b1;
    repeat (4) @(posedge mclk);
    #1 strap_latch = strap_latch ^ s[0];
    repeat (4) @(posedge mclk);
    #1 hw_reset = 1'b0;
    repeat (8) @(posedge mclk);
    #1 strap_wr = ~s[3];
    repeat (8) @(posedge mclk);
    #1 check("host_if", exp, host_if);
    strap_wr = s[3];
  endtask : strap

  // One host command; ready is seen high before the edge that takes it.
  task automatic send(input logic [19:0] e);
    int n;
    cmd_valid = 1'b1;
    cmd_byte  = e[15:8];
    cmd_last  = e[17];
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    check("cmd_ready", 1, cmd_ready);
    @(posedge mclk);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1 n++;
    end
    check("rsp_valid", 1, rsp_valid);
    if (e[16]) check("rsp_byte", e[7:0], rsp_byte);
  endtask : send

  initial begin
    {nrst, hw_reset, strap_wr, strap_rd, strap_latch, irq_req, irq_high, cmd_valid, cmd_last} = '0;
    cmd_byte = 8'h00;
    repeat (4) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("mgmt_only", 1, mgmt_only);
    for (int i = 0; i < 4; i++) begin
      {irq_high, irq_req} = i[1:0];
      repeat (3) @(posedge mclk);
      #1 check("int_line", irq_req == irq_high, int_line);
    end
    strap(4'hE, HOST_PAR_STROBE_DIR);
    strap(4'hC, HOST_PAR_SEPARATE);
    strap(4'hD, HOST_PAR_MUX);
    strap(4'h8, HOST_UNDEF);
    strap(4'h0, HOST_SERIAL);
    check("mgmt_only", 0, mgmt_only);
    foreach (frames[i]) send(frames[i]);
    repeat (20) @(posedge mclk);
    check("write_count", 10, wlog.size());
    check("read_count", 9, rd_count);
    foreach (writes[i]) check("write", writes[i], writes[i][7] ? wlog[i] : {wlog[i][23:7], 7'h00});
    finish_test();
  end

  // Watchdog: the whole run needs about 3000 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    finish_test();
  end
endmodule : host_serial_register_port_tb_top
